//--- rtl/fsbrq_parity.sv
`timescale 1ns/1ps
module fsbrq_parity (
  // wire levels, active low
  input  wire logic [fsbrq_pkg::ADDR_MSB:fsbrq_pkg::ADDR_LSB] addr_n,
  input  wire logic [fsbrq_pkg::REQ_W-1:0]                    req_n,
  // subphase select, high for subphase 2
  input  wire logic                                           sub2,
  // parity wire levels
  output logic      [1:0]                                     par_n
);

  // high when an even number of covered lines are low
  wire hi_par = ~(^(~addr_n[fsbrq_pkg::ADDR_MSB:fsbrq_pkg::PAR_HI_BOT]));
  wire lo_par = ~(^(~{addr_n[fsbrq_pkg::PAR_HI_BOT-1:fsbrq_pkg::ADDR_LSB], req_n}));

  assign par_n = sub2 ? {hi_par, lo_par} : {lo_par, hi_par};

endmodule // fsbrq_parity

//--- rtl/fsbrq_pkg.sv
package fsbrq_pkg;

  // address field bounds on the bus
  localparam int ADDR_LSB     = 3;
  localparam int ADDR_MSB     = 35;
  localparam int REQ_W        = 5;
  // strobe 0 group top bit, strobe 1 group bottom bit
  localparam int STB0_TOP     = 16;
  localparam int STB1_BOT     = 17;
  // parity split: upper group starts here
  localparam int PAR_HI_BOT   = 24;
  // address bit forced low by the mask
  localparam int MASK_BIT     = 20;
  // synchroniser depth
  localparam int SYNC_STAGES  = 3;
  // reset levels
  localparam logic RST_WIRE   = 1'b1;
  localparam logic RST_OE_N   = 1'b1;
  localparam logic RST_TOGGLE = 1'b0;

  typedef logic [ADDR_MSB:ADDR_LSB] fsbrq_addr_t;

  // one request phase, logical (active high) values
  typedef struct packed {
    fsbrq_addr_t      addr;
    logic [REQ_W-1:0] req_a;
    fsbrq_addr_t      info;
    logic [REQ_W-1:0] req_b;
  } fsbrq_req_t;

  // link-side sequencer states
  typedef enum logic [2:0] {
    L_IDLE,
    L_ADS,
    L_FALL,
    L_SUB2,
    L_RISE
  } fsbrq_lstate_t;

endpackage

//--- rtl/fsbrq_sync3.sv
`timescale 1ns/1ps
module fsbrq_sync3 #(
  parameter int   W   = 1,
  parameter logic RST = 1'b0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  wire  [W-1:0] agree = ~(s2_q ^ s3_q);

  // refuse a width the flops cannot hold
  if (W < 1) begin : g_bad_width
    $error("fsbrq_sync3: width must be at least 1");
  end

  // a change counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= {W{RST}};
      s2_q <= {W{RST}};
      s3_q <= {W{RST}};
      q    <= {W{RST}};
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q    <= (q & ~agree) | (s3_q & agree);
    end
  end

endmodule // fsbrq_sync3

//--- rtl/fsbrq_top.sv
`timescale 1ns/1ps
module fsbrq_top (
  // core clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // bus clock
  input  wire logic                  bus_clk,
  // mask pin
  input  wire logic                  addr_bit20_mask_n,
  // core request
  input  wire logic                  tx_valid,
  input  wire fsbrq_pkg::fsbrq_req_t tx_req,
  output logic                       tx_ready_q,
  // core cache lookup address
  input  wire fsbrq_pkg::fsbrq_addr_t lookup_addr,
  output fsbrq_pkg::fsbrq_addr_t     lookup_addr_q,
  output logic                       a20_active_q,
  // observed request
  output logic                       rx_valid_q,
  output fsbrq_pkg::fsbrq_req_t      rx_req_q,
  output logic                       rx_perr_q,
  // address-valid strobe
  input  wire logic                  addr_valid_strobe_n_i,
  output logic                       addr_valid_strobe_n_o,
  output logic                       addr_valid_strobe_oe_n,
  // address lines
  input  wire fsbrq_pkg::fsbrq_addr_t addr_n_i,
  output fsbrq_pkg::fsbrq_addr_t     addr_n_o,
  output logic                       addr_oe_n,
  // request-type lines
  input  wire logic [4:0]            req_n_i,
  output logic      [4:0]            req_n_o,
  output logic                       req_oe_n,
  // source-synchronous strobes
  input  wire logic [1:0]            addr_src_sync_strobe_n_i,
  output logic      [1:0]            addr_src_sync_strobe_n_o,
  output logic                       addr_src_sync_strobe_oe_n,
  // address parity
  input  wire logic [1:0]            addr_parity_n_i,
  output logic      [1:0]            addr_parity_n_o,
  output logic                       addr_parity_oe_n
);

  function automatic fsbrq_pkg::fsbrq_addr_t mask_a20(input fsbrq_pkg::fsbrq_addr_t a, input logic m);
    fsbrq_pkg::fsbrq_addr_t r;
    r = a;
    r[fsbrq_pkg::MASK_BIT] = a[fsbrq_pkg::MASK_BIT] & ~m;
    return r;
  endfunction

  // ---------------- core domain ----------------
  logic                  a20_pin_sync;
  fsbrq_pkg::fsbrq_req_t tx_hold_q;
  logic                  tx_tog_q;
  logic                  ack_seen_q;
  logic                  ack_sync;
  logic                  rx_seen_q;
  logic                  rx_sync;
  logic                  ack_tog_q;
  logic                  rx_tog_q;
  fsbrq_pkg::fsbrq_req_t rx_data_q;
  logic                  rx_perr_lq;

  fsbrq_sync3 #(.W(1), .RST(fsbrq_pkg::RST_WIRE)) u_a20_sync (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .d     (addr_bit20_mask_n),
    .q     (a20_pin_sync)
  );

  fsbrq_sync3 #(.W(2), .RST(fsbrq_pkg::RST_TOGGLE)) u_core_sync (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .d     ({ack_tog_q, rx_tog_q}),
    .q     ({ack_sync, rx_sync})
  );

  wire                   tx_fire  = tx_valid & tx_ready_q;
  wire                   ack_seen = ack_sync ^ ack_seen_q;
  wire                   rx_new   = rx_sync ^ rx_seen_q;
  fsbrq_pkg::fsbrq_req_t tx_masked;
  assign tx_masked      = '{addr: mask_a20(tx_req.addr, a20_active_q), req_a: tx_req.req_a,
                            info: tx_req.info, req_b: tx_req.req_b};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      a20_active_q  <= 1'b0;
      lookup_addr_q <= '0;
      tx_ready_q    <= 1'b0;
      tx_hold_q     <= '0;
      tx_tog_q      <= fsbrq_pkg::RST_TOGGLE;
      ack_seen_q    <= fsbrq_pkg::RST_TOGGLE;
    end else begin
      a20_active_q  <= ~a20_pin_sync;
      lookup_addr_q <= mask_a20(lookup_addr, a20_active_q);
      ack_seen_q    <= ack_sync;
      if (tx_fire) begin
        tx_hold_q <= tx_masked;
        tx_tog_q  <= ~tx_tog_q;
      end
      tx_ready_q    <= tx_fire ? 1'b0 : (ack_seen | (tx_ready_q | (tx_tog_q == ack_sync)));
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_seen_q  <= fsbrq_pkg::RST_TOGGLE;
      rx_valid_q <= 1'b0;
      rx_req_q   <= '0;
      rx_perr_q  <= 1'b0;
    end else begin
      rx_seen_q  <= rx_sync;
      rx_valid_q <= rx_new;
      if (rx_new) begin
        rx_req_q  <= rx_data_q;
        rx_perr_q <= rx_perr_lq;
      end
    end
  end

  // ---------------- bus domain: drive side ----------------
  fsbrq_pkg::fsbrq_lstate_t lst_q;
  fsbrq_pkg::fsbrq_lstate_t lst_d;
  logic                     req_sync;
  logic                     req_seen_q;

  fsbrq_sync3 #(.W(1), .RST(fsbrq_pkg::RST_TOGGLE)) u_link_sync (
    .clk   (bus_clk),
    .rst_n (rst_n),
    .d     (tx_tog_q),
    .q     (req_sync)
  );

  wire start = (req_sync ^ req_seen_q) & (lst_q == fsbrq_pkg::L_IDLE);

  always_comb begin
    case (lst_q)
      fsbrq_pkg::L_IDLE: lst_d = start ? fsbrq_pkg::L_ADS : fsbrq_pkg::L_IDLE;
      fsbrq_pkg::L_ADS:  lst_d = fsbrq_pkg::L_FALL;
      fsbrq_pkg::L_FALL: lst_d = fsbrq_pkg::L_SUB2;
      fsbrq_pkg::L_SUB2: lst_d = fsbrq_pkg::L_RISE;
      fsbrq_pkg::L_RISE: lst_d = fsbrq_pkg::L_IDLE;
      default:           lst_d = fsbrq_pkg::L_IDLE;
    endcase
  end

  wire                    drv_d = (lst_d != fsbrq_pkg::L_IDLE);
  wire                    ads_d = ~(lst_d == fsbrq_pkg::L_ADS);
  wire                    stb_d = ~((lst_d == fsbrq_pkg::L_FALL) | (lst_d == fsbrq_pkg::L_SUB2));
  wire                    sub2_d = (lst_d == fsbrq_pkg::L_SUB2) | (lst_d == fsbrq_pkg::L_RISE);
  fsbrq_pkg::fsbrq_addr_t a_d;
  logic [4:0]             r_d;
  logic [1:0]             p_d;
  assign a_d = sub2_d ? ~tx_hold_q.info : ~tx_hold_q.addr;
  assign r_d = sub2_d ? ~tx_hold_q.req_b : ~tx_hold_q.req_a;

  fsbrq_parity u_tx_par (
    .addr_n (a_d),
    .req_n  (r_d),
    .sub2   (sub2_d),
    .par_n  (p_d)
  );

  // all bus outputs launched on the bus clock
  always_ff @(posedge bus_clk or negedge rst_n) begin
    if (!rst_n) begin
      lst_q                     <= fsbrq_pkg::L_IDLE;
      req_seen_q                <= fsbrq_pkg::RST_TOGGLE;
      ack_tog_q                 <= fsbrq_pkg::RST_TOGGLE;
      addr_valid_strobe_n_o     <= fsbrq_pkg::RST_WIRE;
      addr_valid_strobe_oe_n    <= fsbrq_pkg::RST_OE_N;
      addr_n_o                  <= '1;
      addr_oe_n                 <= fsbrq_pkg::RST_OE_N;
      req_n_o                   <= '1;
      req_oe_n                  <= fsbrq_pkg::RST_OE_N;
      addr_src_sync_strobe_n_o  <= '1;
      addr_src_sync_strobe_oe_n <= fsbrq_pkg::RST_OE_N;
      addr_parity_n_o           <= '1;
      addr_parity_oe_n          <= fsbrq_pkg::RST_OE_N;
    end else begin
      lst_q                     <= lst_d;
      if (start) req_seen_q <= req_sync;
      if (lst_q == fsbrq_pkg::L_RISE) ack_tog_q <= ~ack_tog_q;
      addr_valid_strobe_n_o     <= ads_d;
      addr_valid_strobe_oe_n    <= ~drv_d;
      addr_n_o                  <= drv_d ? a_d : '1;
      addr_oe_n                 <= ~drv_d;
      req_n_o                   <= drv_d ? r_d : '1;
      req_oe_n                  <= ~drv_d;
      addr_src_sync_strobe_n_o  <= {2{stb_d}};
      addr_src_sync_strobe_oe_n <= ~drv_d;
      addr_parity_n_o           <= drv_d ? p_d : '1;
      addr_parity_oe_n          <= ~drv_d;
    end
  end

  // ---------------- bus domain: observe side ----------------
  logic                                          rx_arm_q;
  logic [1:0]                                    stb_prev_q;
  logic [fsbrq_pkg::STB0_TOP:fsbrq_pkg::ADDR_LSB] s1_lo_q;
  logic [4:0]                                    s1_req_q;
  logic [fsbrq_pkg::ADDR_MSB:fsbrq_pkg::STB1_BOT] s1_hi_q;
  logic [fsbrq_pkg::ADDR_MSB:fsbrq_pkg::STB1_BOT] s2_hi_q;
  logic [1:0]                                    par1_q;
  logic [1:0]                                    chk1;
  logic [1:0]                                    chk2;

  wire [1:0] fall = stb_prev_q & ~addr_src_sync_strobe_n_i;
  wire [1:0] rise = ~stb_prev_q & addr_src_sync_strobe_n_i;
  wire [fsbrq_pkg::ADDR_MSB:fsbrq_pkg::STB1_BOT] hi_now =
    rise[1] ? ~addr_n_i[fsbrq_pkg::ADDR_MSB:fsbrq_pkg::STB1_BOT] : s2_hi_q;
  fsbrq_pkg::fsbrq_addr_t s1_addr;
  fsbrq_pkg::fsbrq_addr_t s2_addr;
  assign s1_addr = {s1_hi_q, s1_lo_q};
  assign s2_addr = {hi_now, ~addr_n_i[fsbrq_pkg::STB0_TOP:fsbrq_pkg::ADDR_LSB]};
  wire done = rx_arm_q & rise[0];

  fsbrq_parity u_chk1 (
    .addr_n (~s1_addr),
    .req_n  (~s1_req_q),
    .sub2   (1'b0),
    .par_n  (chk1)
  );

  fsbrq_parity u_chk2 (
    .addr_n (~s2_addr),
    .req_n  (req_n_i),
    .sub2   (1'b1),
    .par_n  (chk2)
  );

  always_ff @(posedge bus_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_arm_q   <= 1'b0;
      stb_prev_q <= '1;
      s1_lo_q    <= '0;
      s1_req_q   <= '0;
      s1_hi_q    <= '0;
      s2_hi_q    <= '0;
      par1_q     <= '1;
    end else begin
      stb_prev_q <= addr_src_sync_strobe_n_i;
      rx_arm_q   <= done ? 1'b0 : (rx_arm_q | ~addr_valid_strobe_n_i);
      if (rx_arm_q & fall[0]) begin
        s1_lo_q  <= ~addr_n_i[fsbrq_pkg::STB0_TOP:fsbrq_pkg::ADDR_LSB];
        s1_req_q <= ~req_n_i;
        par1_q   <= addr_parity_n_i;
      end
      if (rx_arm_q & fall[1]) s1_hi_q <= ~addr_n_i[fsbrq_pkg::ADDR_MSB:fsbrq_pkg::STB1_BOT];
      if (rx_arm_q & rise[1]) s2_hi_q <= ~addr_n_i[fsbrq_pkg::ADDR_MSB:fsbrq_pkg::STB1_BOT];
    end
  end

  always_ff @(posedge bus_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_tog_q   <= fsbrq_pkg::RST_TOGGLE;
      rx_data_q  <= '0;
      rx_perr_lq <= 1'b0;
    end else if (done) begin
      rx_tog_q   <= ~rx_tog_q;
      rx_data_q  <= '{addr: s1_addr, req_a: s1_req_q, info: s2_addr, req_b: ~req_n_i};
      rx_perr_lq <= (chk1 != par1_q) | (chk2 != addr_parity_n_i);
    end
  end

  // ---------------- checks ----------------
  a20_sync_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!addr_bit20_mask_n)[*6] |=> a20_active_q) else $error("mask pin not seen after sync delay");
  a20_force_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (tx_fire && a20_active_q) |=> !tx_hold_q.addr[fsbrq_pkg::MASK_BIT]) else $error("bit 20 not masked on request");
  a20_lookup_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    a20_active_q |=> !lookup_addr_q[fsbrq_pkg::MASK_BIT]) else $error("bit 20 not masked on lookup");
  ads_addr_a: assert property (@(posedge bus_clk) disable iff (!rst_n)
    !addr_valid_strobe_n_o |-> (!addr_oe_n && !req_oe_n && addr_n_o == ~tx_hold_q.addr))
    else $error("address not valid with address strobe");
  strobe_seq_a: assert property (@(posedge bus_clk) disable iff (!rst_n)
    $fell(addr_valid_strobe_n_o) |=> (addr_src_sync_strobe_n_o == 2'b00 && addr_n_o == $past(addr_n_o))
    ##1 (addr_n_o == ~tx_hold_q.info) ##1 (addr_src_sync_strobe_n_o == 2'b11 && !addr_oe_n))
    else $error("strobe sequence broken");
  strobe_pair_a: assert property (@(posedge bus_clk) disable iff (!rst_n)
    addr_src_sync_strobe_n_o[0] == addr_src_sync_strobe_n_o[1] && addr_src_sync_strobe_oe_n == addr_oe_n)
    else $error("strobes split from their lines");
  par_hi_a: assert property (@(posedge bus_clk) disable iff (!rst_n)
    (!addr_parity_oe_n && (!addr_valid_strobe_n_o || $past(!addr_valid_strobe_n_o))) |->
    addr_parity_n_o[0] == ~(^(~addr_n_o[fsbrq_pkg::ADDR_MSB:fsbrq_pkg::PAR_HI_BOT])))
    else $error("parity 0 wrong in subphase 1");
  par_sub2_a: assert property (@(posedge bus_clk) disable iff (!rst_n)
    (!addr_parity_oe_n && $past(addr_src_sync_strobe_n_o == 2'b00) && addr_src_sync_strobe_n_o == 2'b00) |->
    addr_parity_n_o[1] == ~(^(~addr_n_o[fsbrq_pkg::ADDR_MSB:fsbrq_pkg::PAR_HI_BOT])))
    else $error("parity 1 wrong in subphase 2");
  rx_arm_a: assert property (@(posedge bus_clk) disable iff (!rst_n)
    !addr_valid_strobe_n_i |=> rx_arm_q) else $error("address strobe not observed");
  rx_cap_a: assert property (@(posedge bus_clk) disable iff (!rst_n)
    (rx_arm_q && fall[0]) |=> s1_req_q == ~$past(req_n_i)) else $error("falling edge capture missed");

  tx_cov_c: cover property (@(posedge ref_clk) disable iff (!rst_n) tx_fire ##[1:40] tx_ready_q);
  rx_cov_c: cover property (@(posedge ref_clk) disable iff (!rst_n) rx_valid_q && !rx_perr_q);
  perr_cov_c: cover property (@(posedge ref_clk) disable iff (!rst_n) rx_valid_q && rx_perr_q);
  a20_cov_c: cover property (@(posedge ref_clk) disable iff (!rst_n) tx_fire && a20_active_q);

endmodule // fsbrq_top

//--- verif/fsbrq_agent.sv
`timescale 1ns/1ps
module fsbrq_agent (
  // bus clock
  input  wire logic             bus_clk,
  // wire levels driven by the agent
  output logic                  ads_n,
  output fsbrq_pkg::fsbrq_addr_t addr_n,
  output logic [4:0]            req_n,
  output logic [1:0]            stb_n,
  output logic [1:0]            par_n,
  output logic                  oe_n
);
  // parity wire levels: high for an even count of low lines
  function automatic logic [1:0] exp_par(fsbrq_pkg::fsbrq_addr_t a_n, logic [4:0] r_n, logic sub2);
    logic hi;
    logic lo;
    hi = ~(^(~a_n[35:24]));
    lo = ~(^{~a_n[23:3], ~r_n});
    return sub2 ? {hi, lo} : {lo, hi};
  endfunction

  initial begin
    ads_n  = 1'b1;
    addr_n = '1;
    req_n  = '1;
    stb_n  = 2'b11;
    par_n  = 2'b11;
    oe_n   = 1'b1;
  end

  // one request phase, launched on bus clock edges; a bad flag breaks subphase 1 parity
  task automatic issue(input fsbrq_pkg::fsbrq_req_t r, input logic bad);
    @(posedge bus_clk);
    ads_n  <= 1'b0;
    oe_n   <= 1'b0;
    addr_n <= ~r.addr;
    req_n  <= ~r.req_a;
    stb_n  <= 2'b11;
    par_n  <= exp_par(~r.addr, ~r.req_a, 1'b0) ^ {1'b0, bad};
    @(posedge bus_clk);
    stb_n  <= 2'b00;
    @(posedge bus_clk);
    ads_n  <= 1'b1;
    addr_n <= ~r.info;
    req_n  <= ~r.req_b;
    par_n  <= exp_par(~r.info, ~r.req_b, 1'b1);
    @(posedge bus_clk);
    stb_n  <= 2'b11;
    @(posedge bus_clk);
    oe_n   <= 1'b1;
  endtask
endmodule // fsbrq_agent

//--- verif/fsbrq_top_tb.sv
`timescale 1ns/1ps
module fsbrq_top_tb;
  typedef struct packed {
    fsbrq_pkg::fsbrq_req_t req;
    logic                  agent;
    logic                  bad;
  } fsbrq_row_t;

  logic ref_clk, bus_clk, rst_n, addr_bit20_mask_n, tx_valid, tx_ready_q, a20_active_q, rx_valid_q, rx_perr_q;
  logic addr_valid_strobe_n_o, addr_valid_strobe_oe_n, addr_oe_n, req_oe_n, addr_src_sync_strobe_oe_n;
  logic addr_parity_oe_n, agt_ads_n, agt_oe_n;
  logic [4:0] req_n_o, agt_req_n;
  logic [1:0] addr_src_sync_strobe_n_o, addr_parity_n_o, agt_stb_n, agt_par_n;
  fsbrq_pkg::fsbrq_req_t  tx_req, rx_req_q, exp;
  fsbrq_pkg::fsbrq_addr_t lookup_addr, lookup_addr_q, addr_n_o, agt_addr_n;
  logic       [39:0]      mon1, mon2;
  int                     mon_n, n_mismatch, cmp_count;
  fsbrq_row_t             rows [6];

  // wired bus with pull-ups: any driver pulling low wins
  wire        ads_w  = (addr_valid_strobe_oe_n ? 1'b1 : addr_valid_strobe_n_o) & (agt_oe_n ? 1'b1 : agt_ads_n);
  wire [32:0] addr_w = (addr_oe_n ? '1 : addr_n_o) & (agt_oe_n ? '1 : agt_addr_n);
  wire [4:0]  req_w  = (req_oe_n ? '1 : req_n_o) & (agt_oe_n ? '1 : agt_req_n);
  wire [1:0]  stb_w  = (addr_src_sync_strobe_oe_n ? '1 : addr_src_sync_strobe_n_o) & (agt_oe_n ? '1 : agt_stb_n);
  wire [1:0]  par_w  = (addr_parity_oe_n ? '1 : addr_parity_n_o) & (agt_oe_n ? '1 : agt_par_n);

  fsbrq_top fsbrq_top_inst (.ref_clk, .rst_n, .bus_clk, .addr_bit20_mask_n, .tx_valid, .tx_req, .tx_ready_q,
    .lookup_addr, .lookup_addr_q, .a20_active_q, .rx_valid_q, .rx_req_q, .rx_perr_q,
    .addr_valid_strobe_n_i(ads_w), .addr_valid_strobe_n_o, .addr_valid_strobe_oe_n,
    .addr_n_i(addr_w), .addr_n_o, .addr_oe_n, .req_n_i(req_w), .req_n_o, .req_oe_n,
    .addr_src_sync_strobe_n_i(stb_w), .addr_src_sync_strobe_n_o, .addr_src_sync_strobe_oe_n,
    .addr_parity_n_i(par_w), .addr_parity_n_o, .addr_parity_oe_n);

  fsbrq_agent fsbrq_agent_inst (.bus_clk, .ads_n(agt_ads_n), .addr_n(agt_addr_n), .req_n(agt_req_n),
    .stb_n(agt_stb_n), .par_n(agt_par_n), .oe_n(agt_oe_n));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    bus_clk = 1'b0;
    #1.3;
    forever #3 bus_clk = ~bus_clk;
  end

  // capture the design's own wire levels in subphase 1 and subphase 2
  initial mon_n = 0;
  always @(posedge bus_clk) begin
    if (addr_valid_strobe_n_o === 1'b0 && addr_oe_n === 1'b0) begin
      mon1  <= {addr_n_o, req_n_o, addr_parity_n_o};
      mon_n <= 1;
    end else if (mon_n == 1) begin
      mon_n <= 2;
    end else if (mon_n == 2) begin
      mon2  <= {addr_n_o, req_n_o, addr_parity_n_o};
      mon_n <= 0;
    end
  end

  task automatic chk_req(input fsbrq_pkg::fsbrq_req_t got, input fsbrq_pkg::fsbrq_req_t want);
    cmp_count++;
    if (got !== want) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic chk_vec(input logic [39:0] got, input logic [39:0] want);
    cmp_count++;
    if (got !== want) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic chk_bit(input logic got, input logic want);
    cmp_count++;
    if (got !== want) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic end_of_test;
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // offer a request and hold it until taken
  task automatic send(input fsbrq_pkg::fsbrq_req_t r);
    int n;
    n = 0;
    @(posedge ref_clk);
    tx_valid    <= 1'b1;
    tx_req      <= r;
    lookup_addr <= r.addr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (tx_ready_q !== 1'b1 && n < 200);
    tx_valid <= 1'b0;
    if (n >= 200) n_mismatch++;
  endtask

  task automatic wait_rx;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (rx_valid_q !== 1'b1 && n < 300);
    if (n >= 300) n_mismatch++;
    #1;
  endtask

  initial begin
    #100000;
    n_mismatch++;
    end_of_test;
  end

  initial begin
    n_mismatch = 0;
    cmp_count  = 0;
    rst_n = 1'b0;
    tx_valid = 1'b0;
    tx_req = '0;
    lookup_addr = '0;
    addr_bit20_mask_n = 1'b1;
    rows[0] = '{76'h0, 1'b0, 1'b0};
    rows[1] = '{{76{1'b1}}, 1'b0, 1'b0};
    rows[2] = '{76'ha5a5_a5a5_a5a5_a5a5_a5a, 1'b0, 1'b0};
    rows[3] = '{76'h0121_3456_789a_bcde_f01, 1'b0, 1'b0};
    rows[4] = '{76'h5a5a_5a5a_5a5a_5a5a_5a5, 1'b1, 1'b0};
    rows[5] = '{76'h0121_3456_789a_bcde_f01, 1'b1, 1'b1};
    repeat (2) @(posedge ref_clk);
    #1;
    chk_bit(tx_ready_q, 1'b0);
    chk_vec({addr_n_o, req_n_o, addr_parity_n_o}, '1);
    chk_vec(40'({addr_valid_strobe_n_o, addr_valid_strobe_oe_n, addr_oe_n, req_oe_n, addr_src_sync_strobe_oe_n,
      addr_parity_oe_n, addr_src_sync_strobe_n_o}), 40'hff);
    $display("test reset done");
    @(posedge ref_clk) rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      if (rows[i].agent) fsbrq_agent_inst.issue(rows[i].req, rows[i].bad);
      else send(rows[i].req);
      wait_rx;
      chk_req(rx_req_q, rows[i].req);
      chk_bit(rx_perr_q, rows[i].bad);
      if (!rows[i].agent) begin
        chk_vec(mon1, {~rows[i].req.addr, ~rows[i].req.req_a,
          fsbrq_agent_inst.exp_par(~rows[i].req.addr, ~rows[i].req.req_a, 1'b0)});
        chk_vec(mon2, {~rows[i].req.info, ~rows[i].req.req_b,
          fsbrq_agent_inst.exp_par(~rows[i].req.info, ~rows[i].req.req_b, 1'b1)});
        chk_vec(40'(lookup_addr_q), 40'(rows[i].req.addr));
      end
      $display("test row %0d done", i);
    end
    fork
      begin
        send(rows[1].req);
        send(rows[2].req);
      end
      begin
        wait_rx;
        chk_req(rx_req_q, rows[1].req);
        wait_rx;
        chk_req(rx_req_q, rows[2].req);
      end
    join
    $display("test back to back done");
    @(posedge ref_clk) addr_bit20_mask_n <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk_bit(a20_active_q, 1'b0);
    repeat (8) @(posedge ref_clk);
    #1;
    chk_bit(a20_active_q, 1'b1);
    exp = rows[3].req;
    exp.addr[20] = 1'b0;
    send(rows[3].req);
    wait_rx;
    chk_req(rx_req_q, exp);
    chk_vec(40'(lookup_addr_q), 40'(exp.addr));
    @(posedge ref_clk) addr_bit20_mask_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
    chk_bit(a20_active_q, 1'b0);
    $display("test mask done");
    @(posedge ref_clk) rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk_bit(tx_ready_q, 1'b0);
    chk_req(rx_req_q, '0);
    @(posedge ref_clk) rst_n <= 1'b1;
    send(rows[2].req);
    wait_rx;
    chk_req(rx_req_q, rows[2].req);
    $display("test mid reset done");
    end_of_test;
  end
endmodule // fsbrq_top_tb
